// ---- src/msrm_top.sv ----
// register map and general-purpose outputs of the serial mux switch
// assumes framing logic on clk delivers checked 16-bit frames and error events
//
// How it works
// R1 - four general outputs follow upper nibble of switch data
// R2 - general outputs forced low while channel cycling runs
// R3 - switch data 0x01: outputs, three select bits, enable; reset zero
// R4 - four-pair variant: switch data bit 3 reserved, two select bits
// R5 - error config 0x02 resets 0x06: address, count, crc check enables
// R6 - error flags 0x03 read-only: address, count, crc flags
// R7 - burst enable 0x05 bit 0, selects multi-command frames
// R8 - cycle enable 0x06 bit 0 starts conversion-driven channel cycling
// R9 - channel mask 0x07, one bit per channel, reset 0xFF
// R10 - four-pair variant mask uses bits 3..0, reset 0x0F
// R11 - conversion edge select 0x09, one field, rest reserved
// R12 - software reset key 0x0B, read/write, reset zero
// R13 - key writes 0xA3 then 0x05 return all registers to default
// R14 - frame 0x6CA9 clears error flags without address error
// R15 - while cycling only 0xA318 then 0xE3B4 is heard; it exits
// R16 - edge select picks strobe edge that advances the channel
// R17 - reserved bits read zero; writes to error flags count as address errors
`timescale 1ns/1ps
`default_nettype none
module msrm_top #(
   parameter bit FOUR_PAIR = 1'b0
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // frames from serial framing logic
   input  wire logic        frame_valid,
   input  wire logic [15:0] frame_data,
   input  wire logic        crc_err_evt,
   input  wire logic        sclk_err_evt,
   // conversion strobe pin
   input  wire logic        conversion_strobe,
   // read answer
   output logic             rd_valid,
   output logic [7:0]       rd_data,
   // general-purpose outputs
   output logic             gp_out_1,
   output logic             gp_out_2,
   output logic             gp_out_3,
   output logic             gp_out_4,
   // switch control
   output logic             chan_sel_0,
   output logic             chan_sel_1,
   output logic             chan_sel_2,
   output logic             mux_enable,
   output logic             cycle_wrap,
   // modes for the framing logic
   output logic             burst_mode,
   output logic             crc_check,
   output logic             sclk_check,
   output logic             cycling
);
   localparam logic [7:0] SW_WMASK   = FOUR_PAIR ? msrm_pkg::WMASK_SW_FOUR
                                                 : msrm_pkg::WMASK_SW_EIGHT;
   localparam logic [7:0] MASK_RST   = FOUR_PAIR ? msrm_pkg::RST_MASK_FOUR
                                                 : msrm_pkg::RST_MASK_EIGHT;
   localparam logic [7:0] MASK_WMASK = MASK_RST;

   // registers
   logic [7:0] switch_data;
   logic [7:0] error_config;
   logic [7:0] error_flags;
   logic [7:0] burst_enable;
   logic [7:0] cycle_enable;
   logic [7:0] cycle_channel_mask;
   logic [7:0] conversion_edge_select;
   logic [7:0] software_reset_key;
   msrm_pkg::msrm_step_t key_step;
   msrm_pkg::msrm_step_t exit_step;
   logic [7:0] next_switch_data;
   logic [7:0] next_error_config;
   logic [7:0] next_error_flags;
   logic [7:0] next_burst_enable;
   logic [7:0] next_cycle_enable;
   logic [7:0] next_cycle_channel_mask;
   logic [7:0] next_conversion_edge_select;
   logic [7:0] next_software_reset_key;
   msrm_pkg::msrm_step_t next_key_step;
   msrm_pkg::msrm_step_t next_exit_step;
   logic       next_rd_valid;
   logic [7:0] next_rd_data;
   logic       conv_meta;
   logic       conv_sync;
   logic [2:0] sel_bits;

   // frame decode
   logic       is_rd;
   logic [6:0] addr;
   logic [7:0] wdat;
   logic       addr_bad;
   logic       soft_reset;
   logic       clear_flags;
   logic [7:0] set_flags;
   logic [7:0] rd_mux;
   msrm_seq_if sq ();
   msrm_cycle_seq #(
      .N_CHAN (FOUR_PAIR ? 4 : 8)
   ) u_seq (
      .clk   (clk),
      .rst_b (rst_b),
      .sq    (sq.seq)
   );
   assign is_rd = frame_data[msrm_pkg::FRAME_RD_BIT];
   assign addr  = frame_data[msrm_pkg::FRAME_A_MSB:msrm_pkg::FRAME_A_LSB];
   assign wdat  = frame_data[7:0];
   // address check; a write to the flags register counts as bad
   always_comb begin
      unique case (addr)
         msrm_pkg::ADDR_SWITCH_DATA,
         msrm_pkg::ADDR_ERROR_CFG,
         msrm_pkg::ADDR_BURST_EN,
         msrm_pkg::ADDR_CYCLE_EN,
         msrm_pkg::ADDR_CYCLE_MASK,
         msrm_pkg::ADDR_EDGE_SEL,
         msrm_pkg::ADDR_RESET_KEY:   addr_bad = 1'b0;
         msrm_pkg::ADDR_ERROR_FLAGS: addr_bad = !is_rd; // [R6] [R17]
         default:                    addr_bad = 1'b1;
      endcase
   end
   // read mux; reserved bits are held zero so read back zero
   always_comb begin
      unique case (addr)
         msrm_pkg::ADDR_SWITCH_DATA: rd_mux = switch_data;
         msrm_pkg::ADDR_ERROR_CFG:   rd_mux = error_config;
         msrm_pkg::ADDR_ERROR_FLAGS: rd_mux = error_flags;
         msrm_pkg::ADDR_BURST_EN:    rd_mux = burst_enable;
         msrm_pkg::ADDR_CYCLE_EN:    rd_mux = cycle_enable;
         msrm_pkg::ADDR_CYCLE_MASK:  rd_mux = cycle_channel_mask;
         msrm_pkg::ADDR_EDGE_SEL:    rd_mux = conversion_edge_select;
         msrm_pkg::ADDR_RESET_KEY:   rd_mux = software_reset_key;
         default:                    rd_mux = 8'h00;
      endcase
   end
   // next register values from frames and error events
   always_comb begin
      next_switch_data            = switch_data;
      next_error_config           = error_config;
      next_burst_enable           = burst_enable;
      next_cycle_enable           = cycle_enable;
      next_cycle_channel_mask     = cycle_channel_mask;
      next_conversion_edge_select = conversion_edge_select;
      next_software_reset_key     = software_reset_key;
      next_key_step               = key_step;
      next_exit_step              = exit_step;
      next_rd_valid               = 1'b0;
      next_rd_data                = rd_data;
      soft_reset                  = 1'b0;
      clear_flags                 = 1'b0;
      set_flags                   = 8'h00;
      // error events count only when their check is on
      set_flags[msrm_pkg::ERR_CRC_BIT]  = crc_err_evt & error_config[msrm_pkg::ERR_CRC_BIT];
      set_flags[msrm_pkg::ERR_SCLK_BIT] = sclk_err_evt & error_config[msrm_pkg::ERR_SCLK_BIT];
      if (frame_valid) begin
         if (cycle_enable[msrm_pkg::ENABLE_BIT]) begin
            // only the two-frame exit is heard while cycling [R15]
            if (exit_step == msrm_pkg::MSRM_STEP_ARMED
                && frame_data == msrm_pkg::FRAME_EXIT_2) begin
               next_cycle_enable = msrm_pkg::RST_CYCLE_EN; // [R15]
               next_exit_step    = msrm_pkg::MSRM_STEP_IDLE;
            end else if (frame_data == msrm_pkg::FRAME_EXIT_1) begin
               next_exit_step = msrm_pkg::MSRM_STEP_ARMED;
            end else begin
               next_exit_step = msrm_pkg::MSRM_STEP_IDLE;
            end
         end else if (frame_data == msrm_pkg::FRAME_ERR_CLEAR) begin
            clear_flags   = 1'b1;                   // no address error here [R14]
            next_key_step = msrm_pkg::MSRM_STEP_IDLE;
         end else if (addr_bad) begin
            set_flags[msrm_pkg::ERR_ADDR_BIT] = error_config[msrm_pkg::ERR_ADDR_BIT];
            next_key_step = msrm_pkg::MSRM_STEP_IDLE; // no write happens
         end else if (is_rd) begin
            next_rd_valid = 1'b1;
            next_rd_data  = rd_mux;
            next_key_step = msrm_pkg::MSRM_STEP_IDLE;
         end else begin
            next_key_step = msrm_pkg::MSRM_STEP_IDLE;
            unique case (addr)
               msrm_pkg::ADDR_SWITCH_DATA: next_switch_data = wdat & SW_WMASK; // [R3] [R4]
               msrm_pkg::ADDR_ERROR_CFG:
                  next_error_config = wdat & msrm_pkg::WMASK_ERROR_CFG; // [R5]
               msrm_pkg::ADDR_BURST_EN:
                  next_burst_enable = wdat & msrm_pkg::WMASK_ONE_BIT;   // [R7]
               msrm_pkg::ADDR_CYCLE_EN:
                  next_cycle_enable = wdat & msrm_pkg::WMASK_ONE_BIT;   // [R8]
               msrm_pkg::ADDR_CYCLE_MASK:
                  next_cycle_channel_mask = wdat & MASK_WMASK;          // [R9] [R10]
               msrm_pkg::ADDR_EDGE_SEL:
                  next_conversion_edge_select = wdat & msrm_pkg::WMASK_ONE_BIT; // [R11]
               msrm_pkg::ADDR_RESET_KEY: begin
                  next_software_reset_key = wdat & msrm_pkg::WMASK_FULL; // [R12]
                  // key only counts in two back-to-back frames [R13]
                  soft_reset = (key_step == msrm_pkg::MSRM_STEP_ARMED)
                               && (wdat == msrm_pkg::KEY_SECOND);
                  if (wdat == msrm_pkg::KEY_FIRST) begin
                     next_key_step = msrm_pkg::MSRM_STEP_ARMED;
                  end
               end
               default: next_key_step = msrm_pkg::MSRM_STEP_IDLE;
            endcase
         end
      end
      // a new error beats a clear arriving in the same cycle
      next_error_flags = (clear_flags ? msrm_pkg::RST_ERROR_FLAGS : error_flags)
                         | set_flags; // [R14]
      if (soft_reset) begin
         next_switch_data            = msrm_pkg::RST_SWITCH_DATA;  // [R13]
         next_error_config           = msrm_pkg::RST_ERROR_CFG;
         next_error_flags            = msrm_pkg::RST_ERROR_FLAGS;
         next_burst_enable           = msrm_pkg::RST_BURST_EN;
         next_cycle_enable           = msrm_pkg::RST_CYCLE_EN;
         next_cycle_channel_mask     = MASK_RST;
         next_conversion_edge_select = msrm_pkg::RST_EDGE_SEL;
         next_software_reset_key     = msrm_pkg::RST_RESET_KEY;
         next_key_step               = msrm_pkg::MSRM_STEP_IDLE;
      end
   end
   // register file
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         switch_data            <= msrm_pkg::RST_SWITCH_DATA;
         error_config           <= msrm_pkg::RST_ERROR_CFG;
         error_flags            <= msrm_pkg::RST_ERROR_FLAGS;
         burst_enable           <= msrm_pkg::RST_BURST_EN;
         cycle_enable           <= msrm_pkg::RST_CYCLE_EN;
         cycle_channel_mask     <= MASK_RST;
         conversion_edge_select <= msrm_pkg::RST_EDGE_SEL;
         software_reset_key     <= msrm_pkg::RST_RESET_KEY;
         key_step               <= msrm_pkg::MSRM_STEP_IDLE;
         exit_step              <= msrm_pkg::MSRM_STEP_IDLE;
         rd_valid               <= 1'b0;
         rd_data                <= 8'h00;
      end else begin
         switch_data            <= next_switch_data;
         error_config           <= next_error_config;
         error_flags            <= next_error_flags;
         burst_enable           <= next_burst_enable;
         cycle_enable           <= next_cycle_enable;
         cycle_channel_mask     <= next_cycle_channel_mask;
         conversion_edge_select <= next_conversion_edge_select;
         software_reset_key     <= next_software_reset_key;
         key_step               <= next_key_step;
         exit_step              <= next_exit_step;
         rd_valid               <= next_rd_valid;
         rd_data                <= next_rd_data;
      end
   end
   // strobe pin is asynchronous to clk, two stages before use
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_meta <= 1'b0;
         conv_sync <= 1'b0;
      end else begin
         conv_meta <= conversion_strobe;
         conv_sync <= conv_meta;
      end
   end
   assign sq.enable   = cycle_enable[msrm_pkg::ENABLE_BIT];
   assign sq.mask     = cycle_channel_mask;
   assign sq.edge_sel = conversion_edge_select[msrm_pkg::ENABLE_BIT]; // [R16]
   assign sq.conv     = conv_sync;
   // select bits from register or sequencer; upper bit unused for pairs
   assign sel_bits = cycle_enable[msrm_pkg::ENABLE_BIT] ? sq.channel
                   : switch_data[msrm_pkg::SW_SEL_LSB +: 3];
   // output flops; one cycle behind the registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {gp_out_4, gp_out_3, gp_out_2, gp_out_1} <= 4'h0;
         {chan_sel_2, chan_sel_1, chan_sel_0}     <= 3'h0;
         mux_enable <= 1'b0;
         cycle_wrap <= 1'b0;
         burst_mode <= 1'b0;
         crc_check  <= 1'b0;
         sclk_check <= 1'b0;
         cycling    <= 1'b0;
      end else begin
         {gp_out_4, gp_out_3, gp_out_2, gp_out_1} <= cycle_enable[msrm_pkg::ENABLE_BIT]
            ? 4'h0                                         // [R2]
            : switch_data[msrm_pkg::SW_GP_LSB +: 4];       // [R1]
         {chan_sel_2, chan_sel_1, chan_sel_0} <= {sel_bits[2] & ~FOUR_PAIR,
                                                  sel_bits[1:0]}; // [R4]
         mux_enable <= cycle_enable[msrm_pkg::ENABLE_BIT] | switch_data[msrm_pkg::SW_EN_BIT];
         cycle_wrap <= sq.wrap;
         burst_mode <= burst_enable[msrm_pkg::ENABLE_BIT];  // [R7]
         crc_check  <= error_config[msrm_pkg::ERR_CRC_BIT];
         sclk_check <= error_config[msrm_pkg::ERR_SCLK_BIT];
         cycling    <= cycle_enable[msrm_pkg::ENABLE_BIT];  // [R8]
      end
   end
   gp_low_a: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
      cycle_enable[msrm_pkg::ENABLE_BIT] |=> !(gp_out_1 | gp_out_2 | gp_out_3 | gp_out_4))
      else $error("general output high while cycling");
   gp_follow_a: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      !cycle_enable[msrm_pkg::ENABLE_BIT] |=> ({gp_out_4, gp_out_3, gp_out_2, gp_out_1}
         == $past(switch_data[msrm_pkg::SW_GP_LSB +: 4])))
      else $error("general outputs do not follow switch data");
   flags_ro_a: assert property (@(posedge clk) disable iff (!rst_b) // [R17]
      (frame_valid && !is_rd && addr == msrm_pkg::ADDR_ERROR_FLAGS && !crc_err_evt
       && !sclk_err_evt && !cycle_enable[msrm_pkg::ENABLE_BIT])
      |=> $stable(error_flags[msrm_pkg::ERR_SCLK_BIT:msrm_pkg::ERR_CRC_BIT]))
      else $error("write changed the error flags");
   err_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
      (frame_valid && frame_data == msrm_pkg::FRAME_ERR_CLEAR && !crc_err_evt
       && !sclk_err_evt && !cycle_enable[msrm_pkg::ENABLE_BIT])
      |=> error_flags == msrm_pkg::RST_ERROR_FLAGS)
      else $error("clear frame left error flags set");
   bad_addr_a: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
      (frame_valid && addr_bad && frame_data != msrm_pkg::FRAME_ERR_CLEAR
       && !cycle_enable[msrm_pkg::ENABLE_BIT] && error_config[msrm_pkg::ERR_ADDR_BIT])
      |=> error_flags[msrm_pkg::ERR_ADDR_BIT])
      else $error("bad address did not raise its flag");
   soft_reset_a: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
      (frame_valid && !is_rd && addr == msrm_pkg::ADDR_RESET_KEY
       && wdat == msrm_pkg::KEY_SECOND && key_step == msrm_pkg::MSRM_STEP_ARMED
       && !cycle_enable[msrm_pkg::ENABLE_BIT])
      |=> (error_config == msrm_pkg::RST_ERROR_CFG && switch_data == msrm_pkg::RST_SWITCH_DATA
           && software_reset_key == msrm_pkg::RST_RESET_KEY))
      else $error("key sequence did not restore defaults");
   cycle_exit_a: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
      (cycle_enable[msrm_pkg::ENABLE_BIT] && exit_step == msrm_pkg::MSRM_STEP_ARMED
       && frame_valid && frame_data == msrm_pkg::FRAME_EXIT_2)
      |=> !cycle_enable[msrm_pkg::ENABLE_BIT] ##1 !cycling)
      else $error("exit frames did not leave cycling");
   burst_follow_a: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
      $changed(burst_enable) |=> burst_mode == $past(burst_enable[msrm_pkg::ENABLE_BIT]))
      else $error("burst mode output lags its register");
   reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // [R4] [R10]
      ((switch_data & ~SW_WMASK) == 8'h00) && ((cycle_channel_mask & ~MASK_WMASK) == 8'h00))
      else $error("reserved register bit set");
endmodule // msrm_top
`default_nettype wire

// ---- include/msrm_pkg.sv ----
// constants of the mux switch register map: addresses, resets, fields, frames
// assumes a framing block that hands over whole 16-bit frames on clk
package msrm_pkg;
   // register addresses
   localparam logic [6:0] ADDR_SWITCH_DATA = 7'h01;
   localparam logic [6:0] ADDR_ERROR_CFG   = 7'h02;
   localparam logic [6:0] ADDR_ERROR_FLAGS = 7'h03;
   localparam logic [6:0] ADDR_BURST_EN    = 7'h05;
   localparam logic [6:0] ADDR_CYCLE_EN    = 7'h06;
   localparam logic [6:0] ADDR_CYCLE_MASK  = 7'h07;
   localparam logic [6:0] ADDR_EDGE_SEL    = 7'h09;
   localparam logic [6:0] ADDR_RESET_KEY   = 7'h0B;
   // reset values
   localparam logic [7:0] RST_SWITCH_DATA  = 8'h00;
   localparam logic [7:0] RST_ERROR_CFG    = 8'h06;
   localparam logic [7:0] RST_ERROR_FLAGS  = 8'h00;
   localparam logic [7:0] RST_BURST_EN     = 8'h00;
   localparam logic [7:0] RST_CYCLE_EN     = 8'h00;
   localparam logic [7:0] RST_MASK_EIGHT   = 8'hFF;
   localparam logic [7:0] RST_MASK_FOUR    = 8'h0F;
   localparam logic [7:0] RST_EDGE_SEL     = 8'h00;
   localparam logic [7:0] RST_RESET_KEY    = 8'h00;
   // writable bits; reserved bits stay zero
   localparam logic [7:0] WMASK_SW_EIGHT   = 8'hFF;
   localparam logic [7:0] WMASK_SW_FOUR    = 8'hF7;
   localparam logic [7:0] WMASK_ERROR_CFG  = 8'h07;
   localparam logic [7:0] WMASK_ONE_BIT    = 8'h01;
   localparam logic [7:0] WMASK_FULL       = 8'hFF;
   // field positions
   localparam int SW_EN_BIT    = 0;
   localparam int SW_SEL_LSB   = 1;
   localparam int SW_GP_LSB    = 4;
   localparam int ERR_CRC_BIT  = 0;
   localparam int ERR_SCLK_BIT = 1;
   localparam int ERR_ADDR_BIT = 2;
   localparam int ENABLE_BIT   = 0;
   localparam int FRAME_RD_BIT = 15;
   localparam int FRAME_A_MSB  = 14;
   localparam int FRAME_A_LSB  = 8;
   // special frames and key values
   localparam logic [15:0] FRAME_ERR_CLEAR = 16'h6CA9;
   localparam logic [15:0] FRAME_EXIT_1    = 16'hA318;
   localparam logic [15:0] FRAME_EXIT_2    = 16'hE3B4;
   localparam logic [7:0]  KEY_FIRST       = 8'hA3;
   localparam logic [7:0]  KEY_SECOND      = 8'h05;
   // two-step sequence trackers
   typedef enum logic {MSRM_STEP_IDLE, MSRM_STEP_ARMED} msrm_step_t;
endpackage

// ---- include/msrm_seq_if.sv ----
// link between the register map and the channel cycling sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface msrm_seq_if;
   logic       enable;
   logic [7:0] mask;
   logic       edge_sel;
   logic       conv;
   logic [2:0] channel;
   logic       wrap;
   modport ctrl (output enable, mask, edge_sel, conv, input channel, wrap);
   modport seq  (input enable, mask, edge_sel, conv, output channel, wrap);
endinterface
`default_nettype wire

// ---- src/msrm_cycle_seq.sv ----
// channel cycling sequencer: steps through included channels on conversion edges
// assumes conv is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module msrm_cycle_seq #(
   parameter int N_CHAN = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control side
   msrm_seq_if.seq  sq
);
   logic       conv_d;
   logic       active;
   logic [2:0] channel;
   logic       wrap;
   logic       next_active;
   logic [2:0] next_channel;
   logic       next_wrap;
   logic       step;
   logic [3:0] found;

   // first included channel after cur, wrapping; msb flags a hit
   function automatic logic [3:0] msrm_next_incl(logic [2:0] cur, logic [7:0] m);
      logic [3:0] r;
      int         j;
      r = '0;
      for (int k = N_CHAN; k >= 1; k--) begin
         j = (int'(cur) + k) % N_CHAN;
         if (m[j]) begin
            r = {1'b1, 3'(j)};
         end
      end
      return r;
   endfunction

   // selected edge of the strobe advances the channel
   assign step  = sq.edge_sel ? (conv_d & ~sq.conv) : (~conv_d & sq.conv); // [R16]
   assign found = msrm_next_incl(active ? channel : 3'(N_CHAN - 1), sq.mask);

   // next sequencer state
   always_comb begin
      next_active  = sq.enable;
      next_channel = channel;
      next_wrap    = 1'b0;
      if (sq.enable && !active && found[3]) begin
         next_channel = found[2:0];             // start on lowest included [R9]
      end else if (sq.enable && step && found[3]) begin
         next_channel = found[2:0];             // [R16]
         next_wrap    = (found[2:0] <= channel); // loop back to start of sequence
      end
   end

   // registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_d  <= 1'b0;
         active  <= 1'b0;
         channel <= 3'h0;
         wrap    <= 1'b0;
      end else begin
         conv_d  <= sq.conv;
         active  <= next_active;
         channel <= next_channel;
         wrap    <= next_wrap;
      end
   end

   assign sq.channel = channel;
   assign sq.wrap    = wrap;

   seq_step_a: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
      (active && sq.enable && step && (sq.mask != 8'h00)) |=> sq.mask[channel])
      else $error("channel stepped to an excluded channel");
   seq_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
      (active && sq.enable && !step) |=> $stable(channel))
      else $error("channel moved without a conversion edge");
endmodule // msrm_cycle_seq
`default_nettype wire

// ---- verif/msrm_host.sv ----
// host-side frame source standing in for the serial framing logic
// assumes the register map samples frames on the rising clk
`timescale 1ns/1ps
`default_nettype none
module msrm_host (
   // clock
   input  wire logic   clk,
   // frames towards the register map
   output logic        frame_valid,
   output logic [15:0] frame_data
);
   initial begin
      frame_valid = 1'b0;
      frame_data  = 16'h0000;
   end
   // one whole frame per call; key and exit pairs are two back-to-back calls
   task automatic send(input logic [15:0] f);
      @(posedge clk);
      frame_valid <= 1'b1;
      frame_data  <= f;
      @(posedge clk);
      frame_valid <= 1'b0;
      frame_data  <= ~f; // idle bus must not repeat the last frame
   endtask
endmodule // msrm_host
`default_nettype wire

// ---- verif/test_mux_switch_register_map.sv ----
// self-checking bench for the mux switch register map
// assumes msrm_host delivers whole frames, one per call
`timescale 1ns/1ps
`default_nettype none
module test_mux_switch_register_map;
   logic        clk = 1'b0, rst_b = 1'b0, crc_e = 1'b0, sclk_e = 1'b0, strobe = 1'b0;
   logic        frame_valid, rd_valid, g1, g2, g3, g4, c0, c1, c2, men, cyc, wrp, bm, cc, sc;
   logic [15:0] frame_data;
   logic [7:0]  rd_data;
   int          errors = 0, total_checks = 0, cycles = 0;
   logic [7:0]  addrs [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0B};
   logic [7:0]  rsts [8]  = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
   msrm_host i_msrm_host (.clk(clk), .frame_valid(frame_valid), .frame_data(frame_data));
   msrm_top i_msrm_top (.clk(clk), .rst_b(rst_b), .frame_valid(frame_valid),
      .frame_data(frame_data), .crc_err_evt(crc_e), .sclk_err_evt(sclk_e),
      .conversion_strobe(strobe), .rd_valid(rd_valid), .rd_data(rd_data), .gp_out_1(g1),
      .gp_out_2(g2), .gp_out_3(g3), .gp_out_4(g4), .chan_sel_0(c0), .chan_sel_1(c1),
      .chan_sel_2(c2), .mux_enable(men), .cycle_wrap(wrp), .burst_mode(bm), .crc_check(cc),
      .sclk_check(sc), .cycling(cyc));
   // free-running 25 MHz clock
   initial forever #20 clk = ~clk;
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // hang guard, far above the 121 cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         close_out();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // outputs follow one edge after the frame is taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_msrm_host.send({1'b0, a[6:0], d});
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      i_msrm_host.send({1'b1, a[6:0], 8'h00});
      // the answer stands only in the cycle after the frame is taken
      #1;
      chk("rd_valid", 8'h01, {7'h00, rd_valid});
      chk("rd_data", e, rd_data);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++) rd(addrs[i], rsts[i]);
      chk("modes", 8'h01, {5'h00, bm, cc, sc});
      wr(8'h01, 8'h93);
      chk("gp_out", 8'h09, {4'h0, g4, g3, g2, g1});
      chk("switch", 8'h03, {4'h0, c2, c1, c0, men});
      wr(8'h02, 8'hFF);
      wr(8'h05, 8'hFF);
      chk("modes", 8'h07, {5'h00, bm, cc, sc});
      rd(8'h02, 8'h07);
      rd(8'h05, 8'h01);
      wr(8'h03, 8'h55);
      rd(8'h03, 8'h04);
      // both error events in one cycle, both checks now enabled
      @(posedge clk);
      sclk_e <= 1'b1;
      crc_e  <= 1'b1;
      @(posedge clk);
      sclk_e <= 1'b0;
      crc_e  <= 1'b0;
      rd(8'h03, 8'h07);
      i_msrm_host.send(16'h6CA9);
      rd(8'h03, 8'h00);
      wr(8'h0B, 8'hA3);
      wr(8'h0B, 8'h05);
      rd(8'h02, 8'h06);
      rd(8'h01, 8'h00);
      chk("modes", 8'h01, {5'h00, bm, cc, sc});
      wr(8'h01, 8'hF1);
      wr(8'h07, 8'h05);
      wr(8'h06, 8'h01);
      chk("gp_out", 8'h00, {4'h0, g4, g3, g2, g1});
      chk("cycling", 8'h01, {7'h00, cyc});
      chk("chan", 8'h00, {5'h00, c2, c1, c0});
      // rising strobe edge steps to the next included channel, falling edge does not
      @(posedge clk);
      strobe <= 1'b1;
      repeat (6) @(posedge clk);
      strobe <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("chan", 8'h02, {5'h00, c2, c1, c0});
      // next rising edge loops back to the first channel with a one-cycle wrap pulse
      @(posedge clk);
      strobe <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("wrap", 8'h01, {7'h00, wrp});
      @(posedge clk);
      #1;
      chk("wrap", 8'h00, {7'h00, wrp});
      chk("chan", 8'h00, {5'h00, c2, c1, c0});
      // an ordinary write while cycling is ignored
      wr(8'h01, 8'h00);
      i_msrm_host.send(16'hA318);
      i_msrm_host.send(16'hE3B4);
      repeat (3) @(posedge clk);
      #1;
      chk("cycling", 8'h00, {7'h00, cyc});
      chk("gp_out", 8'h0F, {4'h0, g4, g3, g2, g1});
      // falling edge select, cycling entered with the strobe high
      wr(8'h09, 8'h01);
      rd(8'h09, 8'h01);
      wr(8'h06, 8'h01);
      @(posedge clk);
      strobe <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("chan", 8'h02, {5'h00, c2, c1, c0});
      close_out();
   end
endmodule // test_mux_switch_register_map
`default_nettype wire
